//--- common/fid_pkg.sv
// Package for the feature identification register bank.
// Assumes a 32-bit plain register port; each 64-bit register is two words.
package fid_pkg;

  // ==========================================================
  // Register map: byte addresses of 32-bit words
  localparam logic [7:0] ISA0_LO = 8'h00;
  localparam logic [7:0] ISA0_HI = 8'h04;
  localparam logic [7:0] ISA1_LO = 8'h08;
  localparam logic [7:0] ISA1_HI = 8'h0c;
  localparam logic [7:0] MM0_LO = 8'h10;
  localparam logic [7:0] MM0_HI = 8'h14;
  localparam logic [7:0] MM1_LO = 8'h18;
  localparam logic [7:0] MM1_HI = 8'h1c;
  localparam logic [7:0] MM2_LO = 8'h20;
  localparam logic [7:0] MM2_HI = 8'h24;
  localparam logic [7:0] DBG_ISA0_LO = 8'h40;
  localparam logic [7:0] DBG_ISA0_HI = 8'h44;

  // ==========================================================
  // Field values
  localparam logic [3:0] CIPHER_ABSENT = 4'h0;
  localparam logic [3:0] CIPHER_PRESENT = 4'h2;
  localparam int CIPHER_POS = 4;

  localparam logic [63:0] ISA1_VALUE = 64'h0000_0000_0010_0001;
  localparam logic [63:0] MM0_VALUE = 64'h0000_0000_0010_1125;
  localparam logic [63:0] MM1_VALUE = 64'h0000_0000_1021_2122;
  localparam logic [63:0] MM2_VALUE = 64'h0000_0001_0000_1011;

  // Read bus answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } fid_rd_t;

endpackage : fid_pkg

//--- core/fid_regs.sv
// Constant 64-bit feature identification registers behind a plain port.
// Assumes a master issuing one-cycle read or write strobes on clk_i.
//
// Behaviour
// - Cipher field 7:4 is 0 or 2
// - All registers 64-bit, fixed, reserved zero
// - Attr1 bits 23:20 is 1, bits 31:24 and 19:4 zero
// - Attr1 bits 3:0 is 1
// - Mm0 granules 0,0,1; upper half zero
// - Mm0 endian/secure fields 0,1,1
// - Mm0 asid width 2, phys range 5
// - Mm1 xn split 1, spec error 0
// - Mm1 privileged access never 2, regions 1
// - Mm1 hier disable 2, virt host 1
// - Mm1 vmid width 2, access/dirty 2
// - Mm2 bits 35:32 is 1, reserved zero
// - Mm2 virt range 0, error barrier 1
// - Mm2 multi-transfer 0, override 1, sharing 1
// - Debug view mirrors attribute register 0
// - Attribute register 0 not writable
`timescale 1ns/10ps
`default_nettype none

module fid_regs #(
  parameter bit CIPHER_BUILT = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);

  // ==========================================================
  // Fixed contents
  logic [63:0] isa0;
  fid_pkg::fid_rd_t rd_ff;
  fid_pkg::fid_rd_t nxt_rd;

  assign isa0 = {56'h0, (CIPHER_BUILT ? fid_pkg::CIPHER_PRESENT
                                      : fid_pkg::CIPHER_ABSENT), 4'h0};

  // Word lookup; unmapped addresses read as zero
  function automatic logic [31:0] word_at(input logic [7:0] a,
                                          input logic [63:0] i0);
    logic [31:0] w;
    w = 32'h0;
    if (a == fid_pkg::ISA0_LO || a == fid_pkg::DBG_ISA0_LO)
      w = i0[31:0];
    else if (a == fid_pkg::ISA0_HI || a == fid_pkg::DBG_ISA0_HI)
      w = i0[63:32];
    else if (a == fid_pkg::ISA1_LO)
      w = fid_pkg::ISA1_VALUE[31:0];
    else if (a == fid_pkg::ISA1_HI)
      w = fid_pkg::ISA1_VALUE[63:32];
    else if (a == fid_pkg::MM0_LO)
      w = fid_pkg::MM0_VALUE[31:0];
    else if (a == fid_pkg::MM0_HI)
      w = fid_pkg::MM0_VALUE[63:32];
    else if (a == fid_pkg::MM1_LO)
      w = fid_pkg::MM1_VALUE[31:0];
    else if (a == fid_pkg::MM1_HI)
      w = fid_pkg::MM1_VALUE[63:32];
    else if (a == fid_pkg::MM2_LO)
      w = fid_pkg::MM2_VALUE[31:0];
    else if (a == fid_pkg::MM2_HI)
      w = fid_pkg::MM2_VALUE[63:32];
    return w;
  endfunction : word_at

  // ==========================================================
  // Read path; write strobe and data deliberately unused
  always_comb
  begin
    nxt_rd.valid = rd_i;
    nxt_rd.data = rd_i ? word_at(addr_i, isa0) : 32'h0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rd_ff <= '0;
    else
      rd_ff <= nxt_rd;
  end

  assign rdata_o = rd_ff.data;

  // ==========================================================
  // Checks
  sequence rd_at_s(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence

  sequence wr_at_s(logic [7:0] a);
    wr_i && addr_i == a;
  endsequence

  property rd_word_p(logic [7:0] a, logic [31:0] v);
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_at_s(a) |=> (rdata_o == v);
  endproperty

  // Masked compare, so a wrong field names itself
  property fld_p(logic [7:0] a, logic [31:0] m, logic [31:0] v);
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_at_s(a) |=> ((rdata_o & m) == v);
  endproperty

  mm0_lo_a: assert property (rd_word_p(8'h10, 32'h0010_1125))
    else $error("memory_model_0 low word wrong");
  mm0_hi_a: assert property (rd_word_p(8'h14, 32'h0))
    else $error("memory_model_0 high word not zero");
  mm1_lo_a: assert property (rd_word_p(8'h18, 32'h1021_2122))
    else $error("memory_model_1 low word wrong");
  mm1_fld_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == 8'h18) |=> (rdata_o[15:8] == 8'h21))
    else $error("memory_model_1 hier or vhe field wrong");
  mm1_hi_a: assert property (rd_word_p(8'h1c, 32'h0))
    else $error("memory_model_1 high word not zero");
  mm1_vmid_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == 8'h18) |=> (rdata_o[7:0] == 8'h22))
    else $error("memory_model_1 vmid or dirty field wrong");
  mm2_hi_a: assert property (rd_word_p(8'h24, 32'h1))
    else $error("memory_model_2 high word wrong");
  mm2_lo_a: assert property (rd_word_p(8'h20, 32'h0000_1011))
    else $error("memory_model_2 low word wrong");
  mm2_ctl_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == 8'h20) |=> (rdata_o[11:0] == 12'h011))
    else $error("memory_model_2 control fields wrong");
  isa1_lo_a: assert property (rd_word_p(8'h08, 32'h0010_0001))
    else $error("isa_attr_1 low word wrong");
  isa1_dc_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == 8'h08) |=> (rdata_o[3:0] == 4'h1))
    else $error("isa_attr_1 persistence field wrong");
  cipher_fld_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == 8'h00) |=>
      (rdata_o == (CIPHER_BUILT ? 32'h20 : 32'h0)))
    else $error("isa_attr_0 cipher field wrong");
  dbg_view_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == 8'h40) |=>
      (rdata_o == (CIPHER_BUILT ? 32'h20 : 32'h0)))
    else $error("debug view differs from isa_attr_0");
  wr_ignored_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_at_s(fid_pkg::ISA0_LO) ##1 rd_at_s(fid_pkg::ISA0_LO) |=>
      (rdata_o[7:4] == (CIPHER_BUILT ? 4'h2 : 4'h0)))
    else $error("write altered isa_attr_0");
  idle_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!rd_i) |=> (rdata_o == 32'h0))
    else $error("read data without a read strobe");
  unmap_a: assert property (rd_word_p(8'h30, 32'h0))
    else $error("unmapped word not zero");

  rd_valid_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> (rd_ff.valid == $past(rd_i)))
    else $error("read flag does not follow the strobe");

  rst_quiet_a: assert property (@(posedge clk_i)
    $rose(arst_n_i) |-> (rdata_o == 32'h0))
    else $error("read data not zero after reset");

  wr_quiet_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && !rd_i) |=> (rdata_o == 32'h0))
    else $error("write produced read data");

  // ==========================================================
  // Field checks: isa_attr_0 and its debug view
  // Both views must agree in either build of the cipher option
  // Fields outside the covered stretch are held at zero

  isa0_aes_a: assert property (fld_p(fid_pkg::ISA0_LO,
    32'h0000_00f0,
    CIPHER_BUILT ? 32'h0000_0020 : 32'h0000_0000))
    else $error("isa_attr_0 cipher field wrong");

  isa0_res_a: assert property (fld_p(fid_pkg::ISA0_LO,
    32'h0000_000f, 32'h0000_0000))
    else $error("isa_attr_0 low reserved bits not zero");

  isa0_up_a: assert property (fld_p(fid_pkg::ISA0_LO,
    32'hffff_ff00, 32'h0000_0000))
    else $error("isa_attr_0 upper low-word bits not zero");

  isa0_hi_a: assert property (rd_word_p(fid_pkg::ISA0_HI,
    32'h0000_0000))
    else $error("isa_attr_0 high word not zero");

  dbg_aes_a: assert property (fld_p(fid_pkg::DBG_ISA0_LO,
    32'h0000_00f0,
    CIPHER_BUILT ? 32'h0000_0020 : 32'h0000_0000))
    else $error("debug view cipher field wrong");

  dbg_res_a: assert property (fld_p(fid_pkg::DBG_ISA0_LO,
    32'h0000_000f, 32'h0000_0000))
    else $error("debug view low reserved bits not zero");

  dbg_up_a: assert property (fld_p(fid_pkg::DBG_ISA0_LO,
    32'hffff_ff00, 32'h0000_0000))
    else $error("debug view upper low-word bits not zero");

  dbg_hi_a: assert property (rd_word_p(fid_pkg::DBG_ISA0_HI,
    32'h0000_0000))
    else $error("debug view high word not zero");

  // ==========================================================
  // Field checks: isa_attr_1
  // Reserved spans checked apart from the two live fields

  isa1_rcpc_a: assert property (fld_p(fid_pkg::ISA1_LO,
    32'h00f0_0000, 32'h0010_0000))
    else $error("isa_attr_1 acquire load field wrong");

  isa1_top_a: assert property (fld_p(fid_pkg::ISA1_LO,
    32'hff00_0000, 32'h0000_0000))
    else $error("isa_attr_1 bits 31:24 not zero");

  isa1_mid_a: assert property (fld_p(fid_pkg::ISA1_LO,
    32'h000f_fff0, 32'h0000_0000))
    else $error("isa_attr_1 bits 19:4 not zero");

  isa1_hi_a: assert property (rd_word_p(fid_pkg::ISA1_HI,
    32'h0000_0000))
    else $error("isa_attr_1 high word not zero");

  // ==========================================================
  // Field checks: memory_model_0
  // Granule fields: zero means supported for 4k and 64k
  // but one means supported for 16k, so each is checked alone

  mm0_g4k_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'hf000_0000, 32'h0000_0000))
    else $error("memory_model_0 4k granule field wrong");

  mm0_g64k_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h0f00_0000, 32'h0000_0000))
    else $error("memory_model_0 64k granule field wrong");

  mm0_g16k_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h00f0_0000, 32'h0010_0000))
    else $error("memory_model_0 16k granule field wrong");

  mm0_uend_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h000f_0000, 32'h0000_0000))
    else $error("memory_model_0 user endian field wrong");

  mm0_sec_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h0000_f000, 32'h0000_1000))
    else $error("memory_model_0 secure split field wrong");

  mm0_end_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h0000_0f00, 32'h0000_0100))
    else $error("memory_model_0 mixed endian field wrong");

  mm0_asid_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h0000_00f0, 32'h0000_0020))
    else $error("memory_model_0 address space id field wrong");

  mm0_pa_a: assert property (fld_p(fid_pkg::MM0_LO,
    32'h0000_000f, 32'h0000_0005))
    else $error("memory_model_0 physical range field wrong");

  // ==========================================================
  // Field checks: memory_model_1
  // Every nibble of the low word is live; a swapped pair of fields
  // would still pass a whole-word check built the same way

  mm1_xn_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'hf000_0000, 32'h1000_0000))
    else $error("memory_model_1 execute-never split field wrong");

  mm1_spec_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h0f00_0000, 32'h0000_0000))
    else $error("memory_model_1 speculative error field wrong");

  mm1_priv_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h00f0_0000, 32'h0020_0000))
    else $error("memory_model_1 privileged access field wrong");

  mm1_ord_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h000f_0000, 32'h0001_0000))
    else $error("memory_model_1 ordering region field wrong");

  mm1_hier_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h0000_f000, 32'h0000_2000))
    else $error("memory_model_1 hierarchical disable field wrong");

  mm1_host_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h0000_0f00, 32'h0000_0100))
    else $error("memory_model_1 host extension field wrong");

  mm1_vmid_w_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h0000_00f0, 32'h0000_0020))
    else $error("memory_model_1 vm id width field wrong");

  mm1_dirty_a: assert property (fld_p(fid_pkg::MM1_LO,
    32'h0000_000f, 32'h0000_0002))
    else $error("memory_model_1 access and dirty field wrong");

  // ==========================================================
  // Field checks: memory_model_2
  // The only live field of the high word sits at its bottom
  // nibble, so the reserved span above it is checked apart

  mm2_atom_a: assert property (fld_p(fid_pkg::MM2_HI,
    32'h0000_000f, 32'h0000_0001))
    else $error("memory_model_2 atomicity field wrong");

  mm2_hres_a: assert property (fld_p(fid_pkg::MM2_HI,
    32'hffff_fff0, 32'h0000_0000))
    else $error("memory_model_2 bits 63:36 not zero");

  mm2_lres_a: assert property (fld_p(fid_pkg::MM2_LO,
    32'hfff0_0000, 32'h0000_0000))
    else $error("memory_model_2 bits 31:20 not zero");

  mm2_va_a: assert property (fld_p(fid_pkg::MM2_LO,
    32'h000f_0000, 32'h0000_0000))
    else $error("memory_model_2 virtual range field wrong");

  mm2_barrier_a: assert property (fld_p(fid_pkg::MM2_LO,
    32'h0000_f000, 32'h0000_1000))
    else $error("memory_model_2 error barrier field wrong");

  mm2_multi_a: assert property (fld_p(fid_pkg::MM2_LO,
    32'h0000_0f00, 32'h0000_0000))
    else $error("memory_model_2 multi-transfer field wrong");

  mm2_user_a: assert property (fld_p(fid_pkg::MM2_LO,
    32'h0000_00f0, 32'h0000_0010))
    else $error("memory_model_2 user override field wrong");

  mm2_share_a: assert property (fld_p(fid_pkg::MM2_LO,
    32'h0000_000f, 32'h0000_0001))
    else $error("memory_model_2 table sharing field wrong");

endmodule : fid_regs

`default_nettype wire

//--- tb/fid_regs_tb_top.sv
// Self-checking bench for the feature identification register bank.
// Assumes fid_regs and fid_pkg compiled first; 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module fid_regs_tb_top;

  // ==========================================================
  // Stimulus and expectations
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic [31:0] rdata0;
  int n_mismatch = 0;
  int num_checks = 0;
  // Last two addresses are unmapped
  localparam logic [7:0] ADR [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40, 8'h44, 8'h28, 8'hfc};
  localparam logic [31:0] EXP [14] = '{32'h20, 32'h0,
    32'h0010_0001, 32'h0,
    32'h0010_1125, 32'h0,
    32'h1021_2122, 32'h0,
    32'h0000_1011, 32'h1,
    32'h20, 32'h0, 32'h0, 32'h0};

  fid_regs #(.CIPHER_BUILT(1'b1)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  // Second build without the cipher extension
  fid_regs #(.CIPHER_BUILT(1'b0)) uut_plain (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata0));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Back-to-back reads of the whole map, answer checked one cycle later
  task sweep;
    int k;
    logic [31:0] e0;
    for (k = 0; k <= 14; k++)
    begin
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= (k < 14);
      addr_i <= ADR[k % 14];
      #1;
      if (k > 0)
      begin
        e0 = (ADR[k-1] == 8'h00 || ADR[k-1] == 8'h40) ? 32'h0 : EXP[k-1];
        chk(rdata_o, EXP[k-1]);
        chk(rdata0, e0);
      end
    end
    @(posedge clk_i);
    #1;
    chk(rdata_o, 32'h0);
  endtask : sweep

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Tests
  initial
  begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    sweep();
    // Inverted data everywhere; ends on attr 0 so a read follows it
    for (int k = 13; k >= 0; k--)
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= ADR[k];
      wdata_i <= ~EXP[k];
    end
    sweep();
    give_verdict();
  end

  initial
  begin
    repeat (500) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

endmodule : fid_regs_tb_top

`default_nettype wire
